// ===== mel_cfg.svh
// Offsets, field positions, reset values and codes of the error log register bank
`ifndef MEL_CFG_SVH
`define MEL_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets (one 32-bit word each)
// ----------------------------------------------------------------------------
`define MEL_OFS_LINK_STS_LO 8'h00
`define MEL_OFS_LINK_STS_HI 8'h04
`define MEL_OFS_MC_STS_LO 8'h08
`define MEL_OFS_MC_STS_HI 8'h0C
`define MEL_OFS_MC_MISC_LO 8'h10
`define MEL_OFS_MC_MISC_HI 8'h14
`define MEL_OFS_LOG_CTRL 8'h18
`define MEL_OFS_IRQ_STS 8'h1C
`define MEL_OFS_IRQ_EN 8'h20
`define MEL_OFS_IRQ_CLR 8'h24

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MEL_LOG_CTRL_EXT_BIT 1
`define MEL_STS_FIRST_CODE_HI 36
`define MEL_STS_FIRST_CODE_LO 32
`define MEL_MISC_FIRST_VALID_BIT 62
`define MEL_MISC_SECOND_VALID_BIT 63
`define MEL_IRQ_LINK_BIT 0
`define MEL_IRQ_MC_BIT 1
`define MEL_IRQ_FIRST_BIT 2
`define MEL_IRQ_SECOND_BIT 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MEL_RST_REG64 64'h0000_0000_0000_0000
`define MEL_RST_LOG_CTRL 32'h0000_0000
`define MEL_RST_IRQ 4'h0

// ----------------------------------------------------------------------------
// Model-specific memory controller error encodings, status bits 31:16
// ----------------------------------------------------------------------------
`define MEL_MS_ADDR_PAR 16'h0001
`define MEL_MS_WB_DATA_PAR 16'h0002
`define MEL_MS_WR_BE_PAR 16'h0004
`define MEL_MS_SCRUB_CORR 16'h0008
`define MEL_MS_SCRUB_UNCORR 16'h0010
`define MEL_MS_SPARE_CORR 16'h0020
`define MEL_MS_SPARE_UNCORR 16'h0040
`define MEL_MS_NONE 16'h0000

`endif

// ===== mel_pkg.sv
// Types shared by the error log register bank
package mel_pkg;

  // Bus slave answer state
  typedef enum logic [0:0] {
    MEL_BUS_IDLE = 1'b0,
    MEL_BUS_ACK = 1'b1
  } mel_bus_state_t;

  // Kind of memory controller error reported with an event
  typedef enum logic [2:0] {
    MEL_KIND_OTHER = 3'b000,
    MEL_KIND_ADDR_PAR = 3'b001,
    MEL_KIND_WB_DATA_PAR = 3'b010,
    MEL_KIND_WR_BE_PAR = 3'b011,
    MEL_KIND_SCRUB_CORR = 3'b100,
    MEL_KIND_SCRUB_UNCORR = 3'b101,
    MEL_KIND_SPARE_CORR = 3'b110,
    MEL_KIND_SPARE_UNCORR = 3'b111
  } mel_mc_kind_t;

endpackage : mel_pkg

// ===== mel_top.sv
// Error log register bank: link and memory controller status, misc and control
`include "mel_cfg.svh"

module mel_top
  import mel_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link error event
  input wire logic link_evt_i,
  input wire logic [1:0] link_pp_i,
  input wire logic link_t_i,
  input wire logic [3:0] link_rrrr_i,
  input wire logic [1:0] link_ii_i,
  input wire logic [1:0] link_ll_i,
  input wire logic [6:0] link_valid_i,
  // Memory controller error event
  input wire logic mc_evt_i,
  input wire logic [2:0] mc_mem_type_i,
  input wire logic [3:0] mc_channel_i,
  input wire mel_mc_kind_t mc_kind_i,
  input wire logic [18:0] mc_other_info_i,
  input wire logic [6:0] mc_valid_i,
  input wire logic [8:0] mc_addr_info_i,
  input wire logic mc_corr_read_i,
  input wire logic [4:0] mc_dev_code_i,
  input wire logic [15:0] mc_dev_mask_i,
  input wire logic [4:0] mc_dev_rank_i,
  input wire logic [2:0] mc_dev_slot_i,
  input wire logic [4:0] mc_parity_detail_i,
  // Interrupt
  output logic irq_o
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  mel_bus_state_t bus_state_q, bus_state_d;
  logic [31:0] rdata_q, rdata_d;
  logic [63:0] link_sts_q, link_sts_d;
  logic [63:0] mc_sts_q, mc_sts_d;
  logic [63:0] mc_misc_q, mc_misc_d;
  logic [31:0] log_ctrl_q, log_ctrl_d;
  logic [3:0] irq_sts_q, irq_sts_d;
  logic [3:0] irq_en_q, irq_en_d;
  logic [6:0] link_valid_merged;
  logic [6:0] mc_valid_merged;
  logic wr_fire;
  logic ext_log;
  logic mc_ext_corr;
  logic first_fill;
  logic second_fill;
  logic [3:0] irq_set;

  // Byte-lane merge of a write into one register word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Model-specific code for each error kind
  function automatic logic [15:0] kind_code(input mel_mc_kind_t kind);
    logic [15:0] code;
    code = `MEL_MS_NONE;
    case (kind)
      MEL_KIND_ADDR_PAR: code = `MEL_MS_ADDR_PAR;
      MEL_KIND_WB_DATA_PAR: code = `MEL_MS_WB_DATA_PAR;
      MEL_KIND_WR_BE_PAR: code = `MEL_MS_WR_BE_PAR;
      MEL_KIND_SCRUB_CORR: code = `MEL_MS_SCRUB_CORR;
      MEL_KIND_SCRUB_UNCORR: code = `MEL_MS_SCRUB_UNCORR;
      MEL_KIND_SPARE_CORR: code = `MEL_MS_SPARE_CORR;
      MEL_KIND_SPARE_UNCORR: code = `MEL_MS_SPARE_UNCORR;
      default: code = `MEL_MS_NONE;
    endcase
    return code;
  endfunction

  // --------------------------------------------------------------------------
  // Validity indicator merge for both status registers
  // --------------------------------------------------------------------------
  mel_valid_merge u_link_valid (
    .old_i(link_sts_q[63:57]),
    .new_i(link_valid_i),
    .merged_o(link_valid_merged)
  );

  mel_valid_merge u_mc_valid (
    .old_i(mc_sts_q[63:57]),
    .new_i(mc_valid_i),
    .merged_o(mc_valid_merged)
  );

  // --------------------------------------------------------------------------
  // Bus slave: one wait state, ack registered, write lands on the ack edge
  // --------------------------------------------------------------------------
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & (bus_state_q == MEL_BUS_ACK);
  assign wb_ack_o = (bus_state_q == MEL_BUS_ACK);
  assign wb_dat_o = rdata_q;

  // Answer state and read data; unmapped and write-only offsets read zero
  always_comb begin
    bus_state_d = MEL_BUS_IDLE;
    rdata_d = rdata_q;
    case (bus_state_q)
      MEL_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          bus_state_d = MEL_BUS_ACK;
          rdata_d = 32'h0000_0000;
          if (wb_adr_i == `MEL_OFS_LINK_STS_LO) begin
            rdata_d = link_sts_q[31:0];
          end else if (wb_adr_i == `MEL_OFS_LINK_STS_HI) begin
            rdata_d = link_sts_q[63:32];
          end else if (wb_adr_i == `MEL_OFS_MC_STS_LO) begin
            rdata_d = mc_sts_q[31:0];
          end else if (wb_adr_i == `MEL_OFS_MC_STS_HI) begin
            rdata_d = mc_sts_q[63:32];
          end else if (wb_adr_i == `MEL_OFS_MC_MISC_LO) begin
            rdata_d = mc_misc_q[31:0];
          end else if (wb_adr_i == `MEL_OFS_MC_MISC_HI) begin
            rdata_d = mc_misc_q[63:32];
          end else if (wb_adr_i == `MEL_OFS_LOG_CTRL) begin
            rdata_d = log_ctrl_q;
          end else if (wb_adr_i == `MEL_OFS_IRQ_STS) begin
            rdata_d = {28'h0000000, irq_sts_q};
          end else if (wb_adr_i == `MEL_OFS_IRQ_EN) begin
            rdata_d = {28'h0000000, irq_en_q};
          end
        end
      end
      MEL_BUS_ACK: begin
        bus_state_d = MEL_BUS_IDLE; // Ack lasts one cycle, master must drop stb
      end
      default: begin
        bus_state_d = MEL_BUS_IDLE;
      end
    endcase
  end

  // Registers of the bus slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_q <= MEL_BUS_IDLE;
      rdata_q <= 32'h0000_0000;
    end else begin
      bus_state_q <= bus_state_d;
      rdata_q <= rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Error logging
  // --------------------------------------------------------------------------
  assign ext_log = log_ctrl_q[`MEL_LOG_CTRL_EXT_BIT];
  assign mc_ext_corr = mc_evt_i & ext_log & mc_corr_read_i;
  assign first_fill = mc_ext_corr & ~mc_misc_q[`MEL_MISC_FIRST_VALID_BIT];
  // Second slot fills only behind a valid first record, so readers can rely on it
  assign second_fill = mc_ext_corr & mc_misc_q[`MEL_MISC_FIRST_VALID_BIT]
                       & ~mc_misc_q[`MEL_MISC_SECOND_VALID_BIT];

  // Next register values: software writes first, then hardware events win
  always_comb begin
    link_sts_d = link_sts_q;
    mc_sts_d = mc_sts_q;
    mc_misc_d = mc_misc_q;
    log_ctrl_d = log_ctrl_q;
    if (wr_fire) begin
      if (wb_adr_i == `MEL_OFS_LINK_STS_LO) begin
        link_sts_d[31:0] = lane_merge(link_sts_q[31:0], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `MEL_OFS_LINK_STS_HI) begin
        link_sts_d[63:32] = lane_merge(link_sts_q[63:32], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `MEL_OFS_MC_STS_LO) begin
        mc_sts_d[31:0] = lane_merge(mc_sts_q[31:0], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `MEL_OFS_MC_STS_HI) begin
        mc_sts_d[63:32] = lane_merge(mc_sts_q[63:32], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `MEL_OFS_MC_MISC_LO) begin
        mc_misc_d[31:0] = lane_merge(mc_misc_q[31:0], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `MEL_OFS_MC_MISC_HI) begin
        mc_misc_d[63:32] = lane_merge(mc_misc_q[63:32], wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `MEL_OFS_LOG_CTRL) begin
        log_ctrl_d = lane_merge(log_ctrl_q, wb_dat_i, wb_sel_i);
      end
    end
    // Link record: bus-error layout, top nibble of the code zero
    if (link_evt_i) begin
      link_sts_d[15:0] = {4'h0, 1'b1, link_pp_i, link_t_i, link_rrrr_i, link_ii_i,
                          link_ll_i};
      link_sts_d[63:57] = link_valid_merged;
    end
    // Memory controller record
    if (mc_evt_i) begin
      mc_sts_d[15:0] = {8'h00, 1'b1, mc_mem_type_i, mc_channel_i};
      mc_sts_d[31:16] = kind_code(mc_kind_i);
      mc_sts_d[56:38] = mc_other_info_i;
      mc_sts_d[63:57] = mc_valid_merged;
      mc_misc_d[8:0] = mc_addr_info_i;
      if (mc_ext_corr) begin
        mc_sts_d[`MEL_STS_FIRST_CODE_HI:`MEL_STS_FIRST_CODE_LO] = mc_dev_code_i;
      end
      if (!ext_log && (mc_kind_i == MEL_KIND_WB_DATA_PAR || mc_kind_i == MEL_KIND_WR_BE_PAR)) begin
        mc_misc_d[13:9] = mc_parity_detail_i;
      end
    end
    // First device record
    if (first_fill) begin
      mc_misc_d[29:14] = mc_dev_mask_i;
      mc_misc_d[50:46] = mc_dev_rank_i;
      mc_misc_d[58:56] = mc_dev_slot_i;
      mc_misc_d[`MEL_MISC_FIRST_VALID_BIT] = 1'b1;
    end
    // Second device record, kept until software clears bit 63, except bits 13:9, which take the detail of a write parity event when extended logging is off
    if (second_fill) begin
      mc_misc_d[13:9] = mc_dev_code_i;
      mc_misc_d[45:30] = mc_dev_mask_i;
      mc_misc_d[55:51] = mc_dev_rank_i;
      mc_misc_d[61:59] = mc_dev_slot_i;
      mc_misc_d[`MEL_MISC_SECOND_VALID_BIT] = 1'b1;
    end
    // Reserved bits are never stored
    link_sts_d[56:16] = 41'h000_0000_0000;
    mc_sts_d[37] = 1'b0;
    log_ctrl_d[31:2] = 30'h0000_0000;
    log_ctrl_d[0] = 1'b0;
  end

  // Log registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_sts_q <= `MEL_RST_REG64;
      mc_sts_q <= `MEL_RST_REG64;
      mc_misc_q <= `MEL_RST_REG64;
      log_ctrl_q <= `MEL_RST_LOG_CTRL;
    end else begin
      link_sts_q <= link_sts_d;
      mc_sts_q <= mc_sts_d;
      mc_misc_q <= mc_misc_d;
      log_ctrl_q <= log_ctrl_d;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts: sticky status, enable mask, write-one-to-clear register
  // --------------------------------------------------------------------------
  assign irq_set[`MEL_IRQ_LINK_BIT] = link_evt_i;
  assign irq_set[`MEL_IRQ_MC_BIT] = mc_evt_i;
  assign irq_set[`MEL_IRQ_FIRST_BIT] = first_fill;
  assign irq_set[`MEL_IRQ_SECOND_BIT] = second_fill;

  // A set in the clearing cycle wins so no event is lost
  always_comb begin
    irq_sts_d = irq_sts_q;
    irq_en_d = irq_en_q;
    if (wr_fire && wb_adr_i == `MEL_OFS_IRQ_CLR && wb_sel_i[0]) begin
      irq_sts_d = irq_sts_q & ~wb_dat_i[3:0];
    end else if (wr_fire && wb_adr_i == `MEL_OFS_IRQ_EN && wb_sel_i[0]) begin
      irq_en_d = wb_dat_i[3:0];
    end
    irq_sts_d = irq_sts_d | irq_set;
  end

  // Interrupt registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sts_q <= `MEL_RST_IRQ;
      irq_en_q <= `MEL_RST_IRQ;
    end else begin
      irq_sts_q <= irq_sts_d;
      irq_en_q <= irq_en_d;
    end
  end

  assign irq_o = |(irq_sts_q & irq_en_q);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_link_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    link_sts_q[56:16] == 41'h000_0000_0000)
    else $error("link status reserved bits not zero");

  a_link_code_fmt: assert property (@(posedge clk_i) disable iff (rst_i)
    link_evt_i |=> (link_sts_q[15:11] == 5'h01) && (link_sts_q[10:9] == $past(link_pp_i)))
    else $error("link code not in bus-error layout");

  a_mc_code_fmt: assert property (@(posedge clk_i) disable iff (rst_i)
    mc_evt_i |=> (mc_sts_q[15:7] == 9'h001) && (mc_sts_q[3:0] == $past(mc_channel_i)))
    else $error("memory code not in compound layout");

  a_mc_model_code: assert property (@(posedge clk_i) disable iff (rst_i)
    (mc_evt_i && mc_kind_i == MEL_KIND_SPARE_UNCORR) |=> mc_sts_q[31:16] == `MEL_MS_SPARE_UNCORR)
    else $error("model code for uncorrected spare wrong");

  a_first_code_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    mc_ext_corr |=> (mc_sts_q[36:32] == $past(mc_dev_code_i)) && !mc_sts_q[37])
    else $error("first device code not captured");

  a_parity_detail: assert property (@(posedge clk_i) disable iff (rst_i)
    (mc_evt_i && !ext_log && mc_kind_i == MEL_KIND_WR_BE_PAR)
    |=> mc_misc_q[13:9] == $past(mc_parity_detail_i))
    else $error("parity detail not logged");

  a_first_fill: assert property (@(posedge clk_i) disable iff (rst_i)
    first_fill |=> mc_misc_q[62] && (mc_misc_q[29:14] == $past(mc_dev_mask_i))
    && (mc_misc_q[50:46] == $past(mc_dev_rank_i)) && (mc_misc_q[58:56] == $past(mc_dev_slot_i)))
    else $error("first device record wrong");

  a_second_fill: assert property (@(posedge clk_i) disable iff (rst_i)
    second_fill |=> mc_misc_q[63] && mc_misc_q[62] && (mc_misc_q[45:30] == $past(mc_dev_mask_i))
    && (mc_misc_q[55:51] == $past(mc_dev_rank_i)) && (mc_misc_q[61:59] == $past(mc_dev_slot_i)))
    else $error("second device record wrong");

  a_valid_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (mc_evt_i || link_evt_i) |=> (mc_sts_q[63] || !$past(mc_evt_i))
    && (link_sts_q[63] || !$past(link_evt_i)))
    else $error("valid indicator not set on logging");

  a_no_ext_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (mc_evt_i && !ext_log && !wr_fire) |=> $stable(mc_misc_q[63:14]))
    else $error("device fields changed with extended logging off");

  a_ext_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_fire && wb_adr_i == `MEL_OFS_LOG_CTRL && wb_sel_i[0]) |=> ext_log == $past(wb_dat_i[1]))
    else $error("logging control bit 1 not stored");

endmodule // mel_top

// ===== mel_valid_merge.sv
// Validity indicator update for one status register (bits 63:57)
module mel_valid_merge
  import mel_pkg::*;
(
  // Current and reported indicators, bit 6 is status bit 63
  input wire logic [6:0] old_i,
  input wire logic [6:0] new_i,
  // Merged indicators
  output logic [6:0] merged_o
);

  // Valid always set on logging; overflow set when an older record is overwritten
  always_comb begin
    merged_o = new_i;
    merged_o[6] = 1'b1;
    merged_o[5] = new_i[5] | old_i[6];
  end

endmodule // mel_valid_merge

// ===== tb.sv
// Self-checking bench for the error log register bank
`include "mel_cfg.svh"

module tb
  import mel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} mel_note_t;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rnd, ra, rb;
  logic link_evt_i, link_t_i, mc_evt_i, mc_corr_read_i;
  logic [1:0] link_pp_i, link_ii_i, link_ll_i;
  logic [3:0] link_rrrr_i, mc_channel_i;
  logic [6:0] link_valid_i, mc_valid_i;
  logic [2:0] mc_mem_type_i, mc_dev_slot_i;
  mel_mc_kind_t mc_kind_i;
  logic [18:0] mc_other_info_i;
  logic [8:0] mc_addr_info_i;
  logic [4:0] mc_dev_code_i, mc_dev_rank_i, mc_parity_detail_i;
  logic [15:0] mc_dev_mask_i;
  logic [15:0] ms_tab [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004,
                              16'h0008, 16'h0010, 16'h0020, 16'h0040};
  logic [4:0] dc [2], dr [2];
  logic [15:0] dm [2];
  logic [2:0] ds [2];
  logic [31:0] lo_e, hi_e;
  logic two;
  mel_note_t q [$];
  mel_note_t cur;
  int bad_count = 0, cmp_count = 0, cyc_n = 0;

  mel_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_evt_i(link_evt_i), .link_pp_i(link_pp_i),
    .link_t_i(link_t_i), .link_rrrr_i(link_rrrr_i), .link_ii_i(link_ii_i),
    .link_ll_i(link_ll_i), .link_valid_i(link_valid_i), .mc_evt_i(mc_evt_i),
    .mc_mem_type_i(mc_mem_type_i), .mc_channel_i(mc_channel_i), .mc_kind_i(mc_kind_i),
    .mc_other_info_i(mc_other_info_i), .mc_valid_i(mc_valid_i),
    .mc_addr_info_i(mc_addr_info_i), .mc_corr_read_i(mc_corr_read_i),
    .mc_dev_code_i(mc_dev_code_i), .mc_dev_mask_i(mc_dev_mask_i),
    .mc_dev_rank_i(mc_dev_rank_i), .mc_dev_slot_i(mc_dev_slot_i),
    .mc_parity_detail_i(mc_parity_detail_i), .irq_o(irq_o));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Classic cycle; ack is a register, so the value read after the edge is the sampled one
  task automatic wb_acc(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("BAD ack_wait expected 1 seen %b", wb_ack_o);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // A read leaves its expectation for the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input string nm);
    q.push_back('{nm, e, m});
    wb_acc(1'b0, a, 32'h0000_0000);
  endtask

  // Random event fields, held after the pulse so expectations can use them
  task automatic evt(input logic lk, input logic [2:0] k, input logic cr);
    rnd = lfsr(lfsr(rnd));
    ra = rnd;
    rb = lfsr(rnd);
    @(posedge clk_i);
    {link_evt_i, mc_evt_i} <= {lk, ~lk};
    {link_pp_i, link_t_i, link_rrrr_i, link_ii_i, link_ll_i, link_valid_i} <= ra[17:0];
    mc_kind_i <= mel_mc_kind_t'(k);
    mc_corr_read_i <= cr;
    {mc_other_info_i, mc_channel_i, mc_mem_type_i} <= ra[25:0];
    {mc_dev_slot_i, mc_dev_rank_i, mc_dev_code_i, mc_addr_info_i, mc_valid_i} <= rb[28:0];
    mc_dev_mask_i <= ra[31:16];
    mc_parity_detail_i <= rb[31:27];
    @(posedge clk_i);
    {link_evt_i, mc_evt_i} <= 2'b00;
  endtask

  // Watcher: each read answer takes the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (q.size() == 0) begin
        check("unexpected_read", 32'h0000_0001, 32'h0000_0000);
      end else begin
        cur = q.pop_front();
        check(cur.nm, wb_dat_o & cur.m, cur.e & cur.m);
      end
    end
  end

  // Hang guard
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 47'h0F_0000_0000};
    {link_evt_i, link_pp_i, link_t_i, link_rrrr_i, link_ii_i, link_ll_i, link_valid_i} = '0;
    {mc_evt_i, mc_corr_read_i, mc_mem_type_i, mc_channel_i, mc_other_info_i} = '0;
    {mc_valid_i, mc_addr_info_i, mc_dev_code_i, mc_dev_mask_i, mc_dev_rank_i} = '0;
    {mc_dev_slot_i, mc_parity_detail_i} = '0;
    mc_kind_i = MEL_KIND_OTHER;
    rnd = 32'h900A;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Every offset, one unmapped place included, reads zero after reset
    wb_acc(1'b1, 8'h28, 32'hFFFF_FFFF);
    for (int a = 0; a <= 8'h28; a += 4) rd(a[7:0], 32'h0, 32'hFFFF_FFFF, "reset_value");
    $display("test reset done");
    // Link status layout
    for (int i = 0; i < 3; i++) begin
      evt(1'b1, 3'h0, 1'b0);
      rd(`MEL_OFS_LINK_STS_LO, {21'h000001, ra[17:7]}, 32'hFFFF_FFFF, "link_lo");
      // Bit 62 shows an overwritten older record, so only the first event leaves it to the input
      rd(`MEL_OFS_LINK_STS_HI, {1'b1, (i > 0) | ra[5], ra[4:0], 25'h0},
         32'hFFFF_FFFF, "link_hi");
    end
    $display("test link done");
    // Every memory controller kind with extended logging off
    for (int k = 0; k < 8; k++) begin
      evt(1'b0, k[2:0], 1'b1);
      rd(`MEL_OFS_MC_STS_LO, {ms_tab[k], 8'h00, 1'b1, ra[2:0], ra[6:3]},
         32'hFFFF_FFFF, "mc_lo");
      rd(`MEL_OFS_MC_STS_HI, {1'b1, (k > 0) | rb[5], rb[4:0], ra[25:7], 6'h00},
         32'hFFFF_FFFF, "mc_hi");
      rd(`MEL_OFS_MC_MISC_LO, {18'h0, rb[31:27], rb[15:7]},
         (k == 2 || k == 3) ? 32'hFFFF_FFFF : 32'hFFFF_C1FF, "misc_lo");
      rd(`MEL_OFS_MC_MISC_HI, 32'h0, 32'hFFFF_FFFF, "misc_hi");
    end
    $display("test kinds done");
    // Extended logging: two records, a third is dropped
    wb_acc(1'b1, `MEL_OFS_LOG_CTRL, 32'hFFFF_FFFF);
    rd(`MEL_OFS_LOG_CTRL, 32'h0000_0002, 32'hFFFF_FFFF, "log_ctrl");
    wb_acc(1'b1, `MEL_OFS_MC_MISC_LO, 32'h0);
    wb_acc(1'b1, `MEL_OFS_MC_MISC_HI, 32'h0);
    for (int i = 0; i < 3; i++) begin
      evt(1'b0, 3'h4, 1'b1);
      if (i < 2) {dc[i], dm[i], dr[i], ds[i]} = {rb[20:16], ra[31:16], rb[25:21], rb[28:26]};
      two = (i > 0);
      lo_e = {two ? dm[1][1:0] : 2'b00, dm[0], two ? dc[1] : 5'h00, rb[15:7]};
      hi_e = {two, 1'b1, two ? ds[1] : 3'h0, ds[0], two ? dr[1] : 5'h00, dr[0],
              two ? dm[1][15:2] : 14'h0};
      rd(`MEL_OFS_MC_STS_HI, {27'h0, rb[20:16]}, 32'h0000_003F, "first_code");
      rd(`MEL_OFS_MC_MISC_LO, lo_e, 32'hFFFF_FFFF, "ext_lo");
      rd(`MEL_OFS_MC_MISC_HI, hi_e, 32'hFFFF_FFFF, "ext_hi");
    end
    $display("test extended done");
    // Extended logging off again: device fields stay as cleared
    hi_e = {27'h0, rb[20:16]};
    wb_acc(1'b1, `MEL_OFS_LOG_CTRL, 32'h0);
    wb_acc(1'b1, `MEL_OFS_MC_MISC_HI, 32'h0);
    evt(1'b0, 3'h6, 1'b1);
    rd(`MEL_OFS_MC_MISC_HI, 32'h0, 32'hFFFF_FFFF, "off_hi");
    rd(`MEL_OFS_MC_STS_HI, hi_e, 32'h0000_003F, "off_code");
    // One byte lane only: the other three must keep their value
    wb_sel_i <= 4'h4;
    wb_acc(1'b1, `MEL_OFS_MC_MISC_HI, 32'hFFFF_FFFF);
    wb_sel_i <= 4'hF;
    rd(`MEL_OFS_MC_MISC_HI, 32'h00FF_0000, 32'hFFFF_FFFF, "lane_write");
    $display("test ext off done");
    // Interrupt: sticky status, enable mask, clear
    rd(`MEL_OFS_IRQ_STS, 32'h0000_000F, 32'hFFFF_FFFF, "irq_sts");
    check("irq_masked", {31'h0, irq_o}, 32'h0);
    wb_acc(1'b1, `MEL_OFS_IRQ_EN, 32'h0000_0002);
    @(posedge clk_i);
    check("irq_on", {31'h0, irq_o}, 32'h1);
    wb_acc(1'b1, `MEL_OFS_IRQ_CLR, 32'h0000_0002);
    @(posedge clk_i);
    check("irq_cleared", {31'h0, irq_o}, 32'h0);
    rd(`MEL_OFS_IRQ_STS, 32'h0000_000D, 32'hFFFF_FFFF, "irq_sts_clr");
    rd(`MEL_OFS_IRQ_CLR, 32'h0, 32'hFFFF_FFFF, "irq_clr_read");
    $display("test irq done");
    repeat (3) @(posedge clk_i);
    report_and_stop();
  end
endmodule // tb
